// File: rtl/prc_defs.vh
`ifndef PRC_DEFS_VH
`define PRC_DEFS_VH
// Register offsets
`define PRC_ADDR_W 10
`define PRC_OFS_LOOP 10'h010
`define PRC_OFS_RDIV_LO 10'h011
`define PRC_OFS_RDIV_HI 10'h012
`define PRC_OFS_ABL 10'h017
`define PRC_OFS_ROFS 10'h018
`define PRC_OFS_RSEL 10'h01c
`define PRC_OFS_IDIV 10'h1e0
`define PRC_OFS_IPATH 10'h1e1
// Reset values
`define PRC_RST_LOOP 8'h01
`define PRC_RST_ABL 8'h00
`define PRC_RST_ROFS 8'h00
`define PRC_RST_RSEL 8'h00
`define PRC_RST_IDIV 8'h00
`define PRC_RST_IPATH 8'h00
`define PRC_RST_RDIV 14'h0000
// Field positions
`define PRC_LOOP_PWR_LO 0
`define PRC_LOOP_PWR_HI 1
`define PRC_PUMP_MODE_LO 2
`define PRC_PUMP_MODE_HI 3
`define PRC_PUMP_CUR_LO 4
`define PRC_PUMP_CUR_HI 6
`define PRC_POL_BIT 7
`define PRC_ABL_LO 0
`define PRC_ABL_HI 1
`define PRC_DCOFS_BIT 7
`define PRC_RSEL_DIFF_BIT 0
`define PRC_RSEL_SE1_EN_BIT 1
`define PRC_RSEL_SE2_EN_BIT 2
`define PRC_RSEL_SE1_PD_BIT 3
`define PRC_RSEL_SE2_PD_BIT 4
`define PRC_RSEL_XTAL_BIT 5
`define PRC_RSEL_DBL_BIT 6
`define PRC_IDIV_LO 0
`define PRC_IDIV_HI 2
`define PRC_IPATH_BYP_BIT 0
// Encodings
`define PRC_PWR_NORMAL 2'h0
`define PRC_PUMP_HIZ 2'h0
`define PRC_PUMP_UPF 2'h1
`define PRC_PUMP_DNF 2'h2
`define PRC_PUMP_NORM 2'h3
`endif

// File: rtl/prc_pll_ctrl.v
// Functional notes
// - Loop power resets to async power-down
// - Defaults restored on every reset
// - Input divider ratios one to six
// - Loop power zero enables loop
// - Enabled loop feeds oscillator to prescaler
// - Polarity bit selects tuning sense
// - Detector compares reference and feedback dividers
// - Two-bit antibacklash width field
// - Pump mode: hiz, up, down, normal
// - Eight pump current steps
// - Reference inputs off after reset
// - One register selects reference type
// - Dc-offset bit lowers single-ended bias
// - Separate power-down per single-ended buffer
// - Differential receiver off unless selected, loop on
// - Single-ended buffer off if loop off
// - Differential mode powers down single-ended buffers
// - Crystal bit enables maintaining amplifier
// - Optional reference doubler
// - 14-bit reference divider, zero equals one
`timescale 1ns/1ps
`default_nettype none
`include "prc_defs.vh"
module prc_pll_ctrl (
  input wire CLK,
  input wire SYS_RST,
  input wire CE,
  input wire WR_EN,
  input wire RD_EN,
  input wire [9:0] ADDR,
  input wire [7:0] WDATA,
  output reg [7:0] RDATA,
  output reg RD_VALID,
  input wire CLK_IN,
  input wire EXT_OSC,
  input wire REF_IN,
  input wire FB_IN,
  output reg DIST_CLK,
  output reg PRESCALER_IN,
  output reg PUMP_UP,
  output reg PUMP_DN,
  output reg PUMP_HIZ,
  output reg [2:0] PUMP_CURRENT,
  output reg [1:0] ABL_WIDTH,
  output reg LOOP_ON,
  output reg DIFF_RX_ON,
  output reg SE1_BUF_ON,
  output reg SE2_BUF_ON,
  output reg SE_DC_OFFSET,
  output reg CRYSTAL_AMP_ENABLE,
  output reg DOUBLER_ON
);
////////////////////////////////////////////////////////////////////////////////
// Register file
reg [7:0] loop_r;
reg [7:0] abl_r;
reg [7:0] rofs_r;
reg [7:0] rsel_r;
reg [7:0] idiv_r;
reg [7:0] ipath_r;
reg [13:0] rdiv_r;
// Synchronised pins: 0 clock input, 1 oscillator, 2 reference, 3 feedback
wire [3:0] pin_s;
wire [3:0] pin_d;
wire clk_in_s;
wire ext_s;
assign clk_in_s = pin_s[0];
assign ext_s = pin_s[1];
////////////////////////////////////////////////////////////////////////////////
// Address decode, shared by the write and read paths
localparam [3:0] IDX_NONE = 4'h0;
localparam [3:0] IDX_LOOP = 4'h1;
localparam [3:0] IDX_RDLO = 4'h2;
localparam [3:0] IDX_RDHI = 4'h3;
localparam [3:0] IDX_ABL = 4'h4;
localparam [3:0] IDX_ROFS = 4'h5;
localparam [3:0] IDX_RSEL = 4'h6;
localparam [3:0] IDX_IDIV = 4'h7;
localparam [3:0] IDX_IPATH = 4'h8;
function [3:0] prc_reg_idx;
  input [9:0] a;
  begin
    if (a == `PRC_OFS_LOOP) prc_reg_idx = IDX_LOOP;
    else if (a == `PRC_OFS_RDIV_LO) prc_reg_idx = IDX_RDLO;
    else if (a == `PRC_OFS_RDIV_HI) prc_reg_idx = IDX_RDHI;
    else if (a == `PRC_OFS_ABL) prc_reg_idx = IDX_ABL;
    else if (a == `PRC_OFS_ROFS) prc_reg_idx = IDX_ROFS;
    else if (a == `PRC_OFS_RSEL) prc_reg_idx = IDX_RSEL;
    else if (a == `PRC_OFS_IDIV) prc_reg_idx = IDX_IDIV;
    else if (a == `PRC_OFS_IPATH) prc_reg_idx = IDX_IPATH;
    else prc_reg_idx = IDX_NONE;
  end
endfunction
wire [3:0] reg_idx;
assign reg_idx = prc_reg_idx(ADDR);
////////////////////////////////////////////////////////////////////////////////
// Only code zero runs the loop; every other code means powered down
wire [1:0] pwr = loop_r[`PRC_LOOP_PWR_HI:`PRC_LOOP_PWR_LO];
wire loop_on = (pwr == `PRC_PWR_NORMAL);
always @(posedge CLK) begin
  if (SYS_RST) begin
    loop_r <= `PRC_RST_LOOP;
    abl_r <= `PRC_RST_ABL;
    rofs_r <= `PRC_RST_ROFS;
    rsel_r <= `PRC_RST_RSEL;
    idiv_r <= `PRC_RST_IDIV;
    ipath_r <= `PRC_RST_IPATH;
    rdiv_r <= `PRC_RST_RDIV;
  end else if (CE && WR_EN) begin
    if (reg_idx == IDX_LOOP) loop_r <= WDATA;
    else if (reg_idx == IDX_RDLO) rdiv_r[7:0] <= WDATA;
    else if (reg_idx == IDX_RDHI) rdiv_r[13:8] <= WDATA[5:0];
    else if (reg_idx == IDX_ABL) abl_r <= {6'h00, WDATA[1:0]};
    else if (reg_idx == IDX_ROFS) rofs_r <= {WDATA[7], 7'h00};
    else if (reg_idx == IDX_RSEL) rsel_r <= {1'b0, WDATA[6:0]};
    else if (reg_idx == IDX_IDIV) idiv_r <= {5'h00, WDATA[2:0]};
    else if (reg_idx == IDX_IPATH) ipath_r <= {7'h00, WDATA[0]};
  end
end
always @(posedge CLK) begin
  if (SYS_RST) begin
    RDATA <= 8'h00;
    RD_VALID <= 1'b0;
  end else if (CE) begin
    RD_VALID <= RD_EN;
    if (!RD_EN) RDATA <= 8'h00;
    else if (reg_idx == IDX_LOOP) RDATA <= loop_r;
    else if (reg_idx == IDX_RDLO) RDATA <= rdiv_r[7:0];
    else if (reg_idx == IDX_RDHI) RDATA <= {2'h0, rdiv_r[13:8]};
    else if (reg_idx == IDX_ABL) RDATA <= abl_r;
    else if (reg_idx == IDX_ROFS) RDATA <= rofs_r;
    else if (reg_idx == IDX_RSEL) RDATA <= rsel_r;
    else if (reg_idx == IDX_IDIV) RDATA <= idiv_r;
    else if (reg_idx == IDX_IPATH) RDATA <= ipath_r;
    else RDATA <= 8'h00;
  end
end
////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers; stage one read only by stage two
// Third stage only feeds edge detection, never the first stage
wire [3:0] pin_raw;
assign pin_raw = {FB_IN, REF_IN, EXT_OSC, CLK_IN};
genvar gi;
generate
  for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
    reg meta_r;
    reg sync_r;
    reg dly_r;
    always @(posedge CLK) begin
      if (SYS_RST) begin
        meta_r <= 1'b0;
        sync_r <= 1'b0;
        dly_r <= 1'b0;
      end else if (CE) begin
        meta_r <= pin_raw[gi];
        sync_r <= meta_r;
        dly_r <= sync_r;
      end
    end
    assign pin_s[gi] = sync_r;
    assign pin_d[gi] = dly_r;
  end
endgenerate
////////////////////////////////////////////////////////////////////////////////
// Input divider: code 0 gives 2, else code gives ratio, 7 clamps to 6
function [2:0] prc_ratio;
  input [2:0] code;
  begin
    if (code == 3'h0) prc_ratio = 3'h2;
    else if (code == 3'h7) prc_ratio = 3'h6;
    else prc_ratio = code;
  end
endfunction
reg [2:0] icnt_r;
reg iprev_r, dout_r;
wire [2:0] ratio = prc_ratio(idiv_r[2:0]);
wire in_rise = clk_in_s & ~iprev_r;
always @(posedge CLK) begin
  if (SYS_RST) begin
    icnt_r <= 3'h0;
    iprev_r <= 1'b0;
    dout_r <= 1'b0;
  end else if (CE) begin
    iprev_r <= clk_in_s;
    if (in_rise) begin
      if (icnt_r >= ratio - 3'h1) begin
        icnt_r <= 3'h0;
        dout_r <= 1'b1;
      end else begin
        icnt_r <= icnt_r + 3'h1;
        if (icnt_r + 3'h1 >= {1'b0, ratio[2:1]}) dout_r <= 1'b0;
      end
    end
  end
end
// Ratio one passes the input straight; the counter form would lose it
wire div_clk = (ratio == 3'h1) ? clk_in_s : dout_r;
////////////////////////////////////////////////////////////////////////////////
// Reference divider: 0 and 1 both divide by one
reg [13:0] rcnt_r;
reg rpulse_r;
wire ref_rise = pin_s[2] & ~pin_d[2];
wire fb_rise = pin_s[3] & ~pin_d[3];
always @(posedge CLK) begin
  if (SYS_RST) begin
    rcnt_r <= 14'h0000;
    rpulse_r <= 1'b0;
  end else if (CE) begin
    rpulse_r <= 1'b0;
    if (ref_rise) begin
      if (rdiv_r <= 14'h0001 || rcnt_r >= rdiv_r - 14'h0001) begin
        rcnt_r <= 14'h0000;
        rpulse_r <= 1'b1;
      end else rcnt_r <= rcnt_r + 14'h0001;
    end
  end
end
////////////////////////////////////////////////////////////////////////////////
// Phase detector: up/down state, antibacklash stretch by ABL code cycles
reg up_r, dn_r;
reg [1:0] abl_cnt_r;
wire [1:0] pmode = loop_r[`PRC_PUMP_MODE_HI:`PRC_PUMP_MODE_LO];
wire pol_neg = loop_r[`PRC_POL_BIT];
always @(posedge CLK) begin
  if (SYS_RST) begin
    up_r <= 1'b0;
    dn_r <= 1'b0;
    abl_cnt_r <= 2'h0;
  end else if (CE) begin
    // Cleared under the enable so a frozen block keeps its state
    if (!loop_on) begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
      abl_cnt_r <= 2'h0;
    end else if (up_r && dn_r) begin
      if (abl_cnt_r >= abl_r[1:0]) begin
        up_r <= 1'b0;
        dn_r <= 1'b0;
        abl_cnt_r <= 2'h0;
      end else abl_cnt_r <= abl_cnt_r + 2'h1;
    end else begin
      if (rpulse_r) up_r <= 1'b1;
      if (fb_rise) dn_r <= 1'b1;
    end
  end
end
wire det_up = pol_neg ? dn_r : up_r;
wire det_dn = pol_neg ? up_r : dn_r;
////////////////////////////////////////////////////////////////////////////////
// Clock path outputs
always @(posedge CLK) begin
  if (SYS_RST) begin
    DIST_CLK <= 1'b0;
    PRESCALER_IN <= 1'b0;
    LOOP_ON <= 1'b0;
  end else if (CE) begin
    DIST_CLK <= ipath_r[`PRC_IPATH_BYP_BIT] ? clk_in_s : div_clk;
    PRESCALER_IN <= loop_on ? ext_s : 1'b0;
    LOOP_ON <= loop_on;
  end
end
////////////////////////////////////////////////////////////////////////////////
// Pump outputs; a dead loop leaves the pump floating, never driving
always @(posedge CLK) begin
  if (SYS_RST) begin
    PUMP_UP <= 1'b0;
    PUMP_DN <= 1'b0;
    PUMP_HIZ <= 1'b1;
    PUMP_CURRENT <= 3'h0;
    ABL_WIDTH <= 2'h0;
  end else if (CE) begin
    PUMP_CURRENT <= loop_r[`PRC_PUMP_CUR_HI:`PRC_PUMP_CUR_LO];
    ABL_WIDTH <= abl_r[1:0];
    PUMP_HIZ <= !loop_on || pmode == `PRC_PUMP_HIZ;
    PUMP_UP <= loop_on && (pmode == `PRC_PUMP_UPF ||
               (pmode == `PRC_PUMP_NORM && det_up));
    PUMP_DN <= loop_on && (pmode == `PRC_PUMP_DNF ||
               (pmode == `PRC_PUMP_NORM && det_dn));
  end
end
////////////////////////////////////////////////////////////////////////////////
// Reference input controls
// Differential mode or a dead loop forces a single-ended buffer down
function prc_se_on;
  input loop;
  input diff;
  input en;
  input pd;
  begin
    prc_se_on = loop && !diff && en && !pd;
  end
endfunction
always @(posedge CLK) begin
  if (SYS_RST) begin
    DIFF_RX_ON <= 1'b0;
    SE1_BUF_ON <= 1'b0;
    SE2_BUF_ON <= 1'b0;
    SE_DC_OFFSET <= 1'b0;
    CRYSTAL_AMP_ENABLE <= 1'b0;
    DOUBLER_ON <= 1'b0;
  end else if (CE) begin
    DIFF_RX_ON <= loop_on && rsel_r[`PRC_RSEL_DIFF_BIT];
    SE1_BUF_ON <= prc_se_on(loop_on, rsel_r[`PRC_RSEL_DIFF_BIT],
                            rsel_r[`PRC_RSEL_SE1_EN_BIT], rsel_r[`PRC_RSEL_SE1_PD_BIT]);
    SE2_BUF_ON <= prc_se_on(loop_on, rsel_r[`PRC_RSEL_DIFF_BIT],
                            rsel_r[`PRC_RSEL_SE2_EN_BIT], rsel_r[`PRC_RSEL_SE2_PD_BIT]);
    // The offset only matters for ac-coupled single-ended sources
    SE_DC_OFFSET <= rofs_r[`PRC_DCOFS_BIT];
    CRYSTAL_AMP_ENABLE <= rsel_r[`PRC_RSEL_XTAL_BIT];
    DOUBLER_ON <= rsel_r[`PRC_RSEL_DBL_BIT];
  end
end
endmodule
`default_nettype wire

// File: verif/prc_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
module prc_checker (
  input wire logic CLK, SYS_RST, CE, WR_EN, RD_EN,
  input wire logic [9:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic RD_VALID, PRESCALER_IN, PUMP_UP, PUMP_DN, PUMP_HIZ,
  input wire logic LOOP_ON, DIFF_RX_ON, SE1_BUF_ON, SE2_BUF_ON
);
  wire loop_wr = CE && WR_EN && ADDR == 10'h010;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_read_valid: assert property (CE && RD_EN |=> RD_VALID)
    else $error("read answer missing");
  a_reset_defaults: assert property ($fell(SYS_RST) |-> !LOOP_ON && PUMP_HIZ)
    else $error("reset left loop running");
  a_loop_enable: assert property (loop_wr && WDATA[1:0] == 2'h0 |-> ##2 LOOP_ON)
    else $error("loop not enabled");
  a_off_hiz: assert property (!LOOP_ON |-> PUMP_HIZ && !PUMP_UP && !PUMP_DN)
    else $error("pump active with loop off");
  a_prescaler_gated: assert property (!LOOP_ON && !$past(LOOP_ON) |-> !PRESCALER_IN)
    else $error("prescaler fed with loop off");
  a_diff_needs_loop: assert property (DIFF_RX_ON |-> LOOP_ON)
    else $error("diff receiver on with loop off");
  a_se_needs_loop: assert property ((SE1_BUF_ON || SE2_BUF_ON) |-> LOOP_ON)
    else $error("single buffer on with loop off");
  a_diff_blocks_se: assert property (DIFF_RX_ON |-> !SE1_BUF_ON && !SE2_BUF_ON)
    else $error("single buffer on in diff mode");
endmodule
bind prc_pll_ctrl prc_checker u_chk (.*);
`default_nettype wire

// File: verif/prc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module prc_src_model (
  input wire logic CLK,
  output wire logic CLK_IN,
  output wire logic EXT_OSC,
  output wire logic REF_IN,
  output wire logic FB_IN
);
  logic [5:0] cnt_r = 6'h00;
  always @(posedge CLK) cnt_r <= cnt_r + 6'h01;
  // Slow against the sync stages so no level is lost
  assign CLK_IN = cnt_r[1];
  assign EXT_OSC = cnt_r[2];
  // Unequal rates keep the detector busy
  assign REF_IN = cnt_r[5];
  assign FB_IN = cnt_r[4];
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic CLK = 1'b0, SYS_RST = 1'b1, CE = 1'b1, WR_EN = 1'b0, RD_EN = 1'b0;
  logic [9:0] ADDR = 10'h000;
  logic [7:0] WDATA = 8'h00;
  wire [7:0] RDATA;
  wire [2:0] PUMP_CURRENT;
  wire [1:0] ABL_WIDTH;
  wire RD_VALID, CLK_IN, EXT_OSC, REF_IN, FB_IN, DIST_CLK, PRESCALER_IN, PUMP_UP, PUMP_DN;
  wire PUMP_HIZ, LOOP_ON, DIFF_RX_ON, SE1_BUF_ON, SE2_BUF_ON, SE_DC_OFFSET;
  wire CRYSTAL_AMP_ENABLE, DOUBLER_ON;
  wire [7:0] pins = {PUMP_HIZ, PUMP_UP, PUMP_DN, LOOP_ON, DIFF_RX_ON, SE1_BUF_ON, SE2_BUF_ON,
    CRYSTAL_AMP_ENABLE};
  wire [7:0] misc = {DOUBLER_ON, SE_DC_OFFSET, ABL_WIDTH, 1'b0, PUMP_CURRENT};
  int bad_count = 0, cmp_count = 0, seed, nu, nd;
  logic [7:0] exp_q[$];
  logic [9:0] ra[8] = '{10'h010, 10'h011, 10'h012, 10'h017, 10'h018, 10'h01c, 10'h1e0, 10'h1e1};
  logic [7:0] rm[8] = '{8'hff, 8'hff, 8'h3f, 8'h03, 8'h80, 8'h7f, 8'h07, 8'h01};
  logic [7:0] d, mk;
  logic [1:0] k;
  prc_pll_ctrl dut (.*);
  prc_src_model src (.*);
  initial forever #2 CLK = ~CLK;
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(negedge CLK);
    ADDR = a;
    WDATA = v;
    WR_EN = 1'b1;
    @(negedge CLK);
    WR_EN = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(negedge CLK);
    ADDR = a;
    RD_EN = 1'b1;
    exp_q.push_back(e);
    @(negedge CLK);
    RD_EN = 1'b0;
  endtask
  task automatic dflt;
    for (int i = 0; i < 8; i++) rd(ra[i], {7'h00, i == 0});
    chk("pins", 8'h80, pins);
    chk("misc", 8'h00, misc);
  endtask
  task automatic refsel(input logic [7:0] v, input logic [3:0] e);
    wr(10'h01c, v);
    repeat (3) @(negedge CLK);
    chk("ref", {4'h0, e}, pins & 8'h0f);
    chk("dbl", {v[6], 7'h00}, misc & 8'h80);
  endtask
  // Measures one divided clock period in system clocks
  task automatic per(input logic [7:0] c, input logic b, input logic [7:0] e);
    int n;
    logic p;
    wr(10'h1e0, c);
    wr(10'h1e1, {7'h00, b});
    repeat (40) @(negedge CLK);
    for (int j = 0; j < 60; j++) begin
      p = DIST_CLK;
      @(negedge CLK);
      if (DIST_CLK && !p) break;
    end
    n = 0;
    for (int j = 0; j < 60; j++) begin
      p = DIST_CLK;
      @(negedge CLK);
      n++;
      if (DIST_CLK && !p) break;
    end
    chk("dist", e, 8'(n));
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(negedge CLK) begin
    if (RD_VALID === 1'b1) begin
      if (exp_q.size() == 0) bad_count++;
      else chk("rdata", exp_q.pop_front(), RDATA);
    end
  end
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    seed = $urandom(99572);
    repeat (6) @(negedge CLK);
    SYS_RST = 1'b0;
    dflt();
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      wr(ra[i], d);
      rd(ra[i], d & rm[i]);
    end
    wr(10'h3ff, 8'hff);
    rd(10'h3ff, 8'h00);
    per(8'h00, 1'b0, 8'h08);
    per(8'h01, 1'b0, 8'h04);
    per(8'h03, 1'b0, 8'h0c);
    per(8'h06, 1'b0, 8'h18);
    per(8'h05, 1'b1, 8'h04);
    for (int m = 0; m < 4; m++) begin
      d = 8'($urandom);
      wr(10'h010, {1'b0, d[2:0], 2'(m), 2'h0});
      repeat (3) @(negedge CLK);
      // Normal mode lets the detector drive up and down, so mask them
      mk = (m == 3) ? 8'h90 : 8'hf0;
      chk("pump", {m == 0, m == 1, m == 2, 5'h10} & mk, pins & mk);
      chk("cur", {5'h00, d[2:0]}, misc & 8'h07);
    end
    refsel(8'h07, 4'h8);
    refsel(8'h0e, 4'h2);
    refsel(8'h36, 4'h5);
    refsel(8'h46, 4'h6);
    for (int q = 0; q < 2; q++) begin
      wr(10'h010, {q[0], 7'h0c});
      nu = 0;
      nd = 0;
      repeat (128) begin
        @(negedge CLK);
        nu += PUMP_UP;
        nd += PUMP_DN;
      end
      chk("pol", {7'h00, q[0]}, {7'h00, nu > nd});
    end
    wr(10'h010, 8'h01);
    repeat (3) @(negedge CLK);
    chk("loopoff", 8'h80, pins & 8'hfe);
    k = 2'($urandom);
    wr(10'h017, {6'h00, k});
    wr(10'h018, 8'h80);
    repeat (3) @(negedge CLK);
    chk("abl", {2'h1, k, 4'h0}, misc & 8'h70);
    CE = 1'b0;
    wr(10'h017, ~{6'h00, k});
    CE = 1'b1;
    rd(10'h017, {6'h00, k});
    SYS_RST = 1'b1;
    repeat (2) @(negedge CLK);
    SYS_RST = 1'b0;
    dflt();
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge CLK);
    if (exp_q.size() > 0) bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
